/* File: pkg/sspc_pkg.sv */
// constants, carrier structs and state types for the serial port register bank
package sspc_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_BUFFER   = 8'h08;
  localparam logic [7:0] OFS_ADDRDIV  = 8'h0C;
  localparam logic [7:0] OFS_SEQUENCE = 8'h10;

  // status bit positions
  localparam int ST_SMP = 7;
  localparam int ST_CKE = 6;
  localparam int ST_DA  = 5;
  localparam int ST_P   = 4;
  localparam int ST_S   = 3;
  localparam int ST_RW  = 2;
  localparam int ST_UA  = 1;
  localparam int ST_BF  = 0;
  // control bit positions
  localparam int CT_WRITE_COLLISION_FLAG = 7;
  localparam int CT_OVF  = 6;
  localparam int CT_EN   = 5;
  localparam int CT_CKP  = 4;

  // reset values
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [4:0] RST_SEQ     = 5'h00;

  // mode codes
  localparam logic [3:0] MD_SPI_M4    = 4'h0;
  localparam logic [3:0] MD_SPI_M16   = 4'h1;
  localparam logic [3:0] MD_SPI_M64   = 4'h2;
  localparam logic [3:0] MD_SPI_MTMR  = 4'h3;
  localparam logic [3:0] MD_SPI_S_SS  = 4'h4;
  localparam logic [3:0] MD_SPI_S     = 4'h5;
  localparam logic [3:0] MD_I2C_S7    = 4'h6;
  localparam logic [3:0] MD_I2C_S10   = 4'h7;
  localparam logic [3:0] MD_I2C_M     = 4'h8;
  localparam logic [3:0] MD_LOAD_MASK = 4'h9;
  localparam logic [3:0] MD_I2C_FW    = 4'hB;
  localparam logic [3:0] MD_I2C_S7I   = 4'hE;
  localparam logic [3:0] MD_I2C_S10I  = 4'hF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} sspc_wr_t;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESP = 1'b1} sspc_rd_t;

  // events from the shift engine, same clock
  typedef struct packed {
    logic       byte_done;
    logic [7:0] rx_byte;
    logic       rx_is_data;
    logic       start_seen;
    logic       stop_seen;
    logic       addr_match;
    logic       addr_rw;
    logic       nack_seen;
    logic       ua_req;
    logic       tx_busy;
    logic       tx_done;
    logic [4:0] seq_done;
  } sspc_evt_t;

  // configuration towards the shift engine and pin muxes
  typedef struct packed {
    logic       pins_owned;
    logic       spi_master;
    logic [1:0] rate_sel;
    logic       rate_timer;
    logic       spi_slave;
    logic       ss_gating;
    logic       i2c_slave;
    logic       addr10;
    logic       cond_irq_en;
    logic       i2c_master;
    logic       fw_master;
    logic       load_mask;
    logic       clk_idle_high;
    logic       shift_on_rise;
    logic       sample_at_end;
    logic       slew_limit_en;
    logic       scl_hold;
    logic [4:0] seq_enable;
    logic       port_idle;
    logic [7:0] addr_div;
  } sspc_cfg_t;

endpackage

/* File: src/sspc_regs.sv */
// register bank and flag logic of the synchronous serial port, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module sspc_regs (
  input  wire logic               clk_sys_i,
  input  wire logic               arst_n_i,
  input  wire logic [7:0]         s_axi_awaddr_i,
  input  wire logic               s_axi_awvalid_i,
  output logic                    s_axi_awready_o,
  input  wire logic [31:0]        s_axi_wdata_i,
  input  wire logic [3:0]         s_axi_wstrb_i,
  input  wire logic               s_axi_wvalid_i,
  output logic                    s_axi_wready_o,
  output logic [1:0]              s_axi_bresp_o,
  output logic                    s_axi_bvalid_o,
  input  wire logic               s_axi_bready_i,
  input  wire logic [7:0]         s_axi_araddr_i,
  input  wire logic               s_axi_arvalid_i,
  output logic                    s_axi_arready_o,
  output logic [31:0]             s_axi_rdata_o,
  output logic [1:0]              s_axi_rresp_o,
  output logic                    s_axi_rvalid_o,
  input  wire logic               s_axi_rready_i,
  input  wire sspc_pkg::sspc_evt_t evt_i,
  output sspc_pkg::sspc_cfg_t     cfg_o,
  output logic                    tx_load_o,
  output logic [7:0]              tx_byte_o,
  output logic                    byte_irq_o
);
  import sspc_pkg::*;

  typedef struct packed {
    sspc_wr_t   wr_st;
    logic       aw_full;
    logic [7:0] aw_addr;
    logic       w_full;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic       awready;
    logic       wready;
    logic [1:0] bresp;
    sspc_rd_t   rd_st;
    logic       arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] status;
    logic [7:0] control;
    logic [7:0] xfer_buf;
    logic [7:0] addr_div;
    logic [4:0] seq;
    sspc_cfg_t  cfg;
    logic       tx_load;
    logic       byte_irq;
  } sspc_state_t;

  sspc_state_t st_reg;
  sspc_state_t st_next;

  // i2c family decode, shared by flags and configuration
  function automatic logic mode_is_i2c(input logic [3:0] m);
    return (m == MD_I2C_S7) || (m == MD_I2C_S10) || (m == MD_I2C_M) ||
           (m == MD_I2C_FW) || (m == MD_I2C_S7I) || (m == MD_I2C_S10I);
  endfunction

  function automatic logic mode_is_i2c_slave(input logic [3:0] m);
    return (m == MD_I2C_S7) || (m == MD_I2C_S10) ||
           (m == MD_I2C_S7I) || (m == MD_I2C_S10I);
  endfunction

  function automatic logic mode_is_spi_slave(input logic [3:0] m);
    return (m == MD_SPI_S_SS) || (m == MD_SPI_S);
  endfunction

  function automatic logic mode_is_spi_master(input logic [3:0] m);
    return (m[3:2] == 2'b00);
  endfunction

  // local decode of the current mode
  logic [3:0] mode;
  logic       in_i2c;
  logic       in_i2c_m;
  logic       slave_mode;
  logic       bus_idle;
  logic       do_write;
  logic       wr_hit;
  logic       rd_hit;
  logic [7:0] rd_val;
  logic       collide;
  logic       buf_wr;
  logic       buf_rd;

  always_comb begin
    mode       = st_reg.control[3:0];
    in_i2c     = mode_is_i2c(mode);
    in_i2c_m   = (mode == MD_I2C_M) || (mode == MD_I2C_FW);
    slave_mode = mode_is_spi_slave(mode) || mode_is_i2c_slave(mode);
    bus_idle   = ~(st_reg.status[ST_RW] | (|st_reg.seq));
  end

  // address decode for write and read paths
  always_comb begin
    do_write = st_reg.aw_full && st_reg.w_full && (st_reg.wr_st == WR_IDLE);
    wr_hit   = (st_reg.aw_addr == OFS_STATUS) || (st_reg.aw_addr == OFS_CONTROL) ||
               (st_reg.aw_addr == OFS_BUFFER) || (st_reg.aw_addr == OFS_ADDRDIV) ||
               (st_reg.aw_addr == OFS_SEQUENCE);
    rd_hit   = 1'b1;
    rd_val   = 8'h00;
    unique case (s_axi_araddr_i)
      OFS_STATUS:   rd_val = st_reg.status;
      OFS_CONTROL:  rd_val = st_reg.control;
      OFS_BUFFER:   rd_val = st_reg.xfer_buf;
      OFS_ADDRDIV:  rd_val = st_reg.addr_div;
      OFS_SEQUENCE: rd_val = {3'h0, st_reg.seq};
      default:      rd_hit = 1'b0;
    endcase
    buf_wr  = do_write && st_reg.w_lane0 && (st_reg.aw_addr == OFS_BUFFER);
    buf_rd  = s_axi_arvalid_i && st_reg.arready && (s_axi_araddr_i == OFS_BUFFER);
    // a write that the transfer cannot accept now is dropped
    collide = evt_i.tx_busy || (in_i2c_m && !bus_idle);
  end

  // next state of bus slave, registers and flags
  always_comb begin
    st_next = st_reg;
    st_next.tx_load  = 1'b0;
    st_next.byte_irq = 1'b0;

    // write address and data are taken independently
    if (s_axi_awvalid_i && st_reg.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_reg.wready) begin
      st_next.w_full  = 1'b1;
      st_next.w_byte  = s_axi_wdata_i[7:0];
      st_next.w_lane0 = s_axi_wstrb_i[0];
    end
    if (do_write) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.wr_st   = WR_RESP;
      st_next.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if ((st_reg.wr_st == WR_RESP) && s_axi_bready_i) begin
      st_next.wr_st = WR_IDLE;
    end
    st_next.awready = !st_next.aw_full && (st_next.wr_st == WR_IDLE);
    st_next.wready  = !st_next.w_full && (st_next.wr_st == WR_IDLE);

    // read path, one outstanding read
    if (s_axi_arvalid_i && st_reg.arready) begin
      st_next.rd_st = RD_RESP;
      st_next.rdata = {24'h000000, rd_val};
      st_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if ((st_reg.rd_st == RD_RESP) && s_axi_rready_i) begin
      st_next.rd_st = RD_IDLE;
    end
    st_next.arready = (st_next.rd_st == RD_IDLE);

    // software writes, low byte lane only
    if (do_write && st_reg.w_lane0) begin
      unique case (st_reg.aw_addr)
        OFS_STATUS: begin
          st_next.status[ST_SMP] = st_reg.w_byte[ST_SMP];
          st_next.status[ST_CKE] = st_reg.w_byte[ST_CKE];
        end
        OFS_CONTROL: begin
          // flags only clear from software, events below win
          st_next.control[CT_WRITE_COLLISION_FLAG] = st_reg.control[CT_WRITE_COLLISION_FLAG] & st_reg.w_byte[CT_WRITE_COLLISION_FLAG];
          st_next.control[CT_OVF]  = st_reg.control[CT_OVF] & st_reg.w_byte[CT_OVF];
          st_next.control[5:0]     = st_reg.w_byte[5:0];
        end
        OFS_ADDRDIV: begin
          st_next.addr_div      = st_reg.w_byte;
          st_next.status[ST_UA] = 1'b0;
        end
        OFS_SEQUENCE: begin
          if (bus_idle) begin
            st_next.seq = st_reg.w_byte[4:0];
          end
        end
        OFS_BUFFER: begin
          if (collide) begin
            st_next.control[CT_WRITE_COLLISION_FLAG] = 1'b1;
          end else begin
            st_next.xfer_buf = st_reg.w_byte;
            st_next.tx_load  = 1'b1;
            if (in_i2c) begin
              st_next.status[ST_BF] = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // buffer read empties it
    if (buf_rd) begin
      st_next.status[ST_BF] = 1'b0;
    end
    // i2c transmit data bits finished
    if (in_i2c && evt_i.tx_done) begin
      st_next.status[ST_BF] = 1'b0;
    end
    // engine finished a master sequence
    st_next.seq = st_next.seq & ~evt_i.seq_done;

    // completed byte moves to buffer unless the buffer is still full
    // a buffer read in the same cycle frees it, so the new byte lands
    if (evt_i.byte_done) begin
      st_next.byte_irq = 1'b1;
      if (st_reg.status[ST_BF] && !buf_rd) begin
        st_next.control[CT_OVF] = 1'b1;
      end else begin
        st_next.xfer_buf      = evt_i.rx_byte;
        st_next.status[ST_BF] = 1'b1;
      end
      if (in_i2c) begin
        st_next.status[ST_DA] = evt_i.rx_is_data;
      end
    end

    // bus conditions, last one seen wins
    if (evt_i.start_seen) begin
      st_next.status[ST_S] = 1'b1;
      st_next.status[ST_P] = 1'b0;
    end
    if (evt_i.stop_seen) begin
      st_next.status[ST_P] = 1'b1;
      st_next.status[ST_S] = 1'b0;
    end

    // direction flag depends on master or slave role
    if (in_i2c_m) begin
      st_next.status[ST_RW] = evt_i.tx_busy;
    end else if (evt_i.addr_match) begin
      st_next.status[ST_RW] = evt_i.addr_rw;
    end else if (evt_i.start_seen || evt_i.stop_seen || evt_i.nack_seen) begin
      st_next.status[ST_RW] = 1'b0;
    end
    if (evt_i.ua_req && st_reg.control[0] && mode_is_i2c_slave(mode)) begin
      st_next.status[ST_UA] = 1'b1;
    end

    // disabled port drops bus condition flags and sequences
    if (!st_next.control[CT_EN]) begin
      st_next.status[ST_S] = 1'b0;
      st_next.status[ST_P] = 1'b0;
      st_next.seq          = RST_SEQ;
    end

    // configuration seen by the engine, registered
    st_next.cfg.pins_owned    = st_next.control[CT_EN];
    st_next.cfg.spi_master    = mode_is_spi_master(st_next.control[3:0]);
    st_next.cfg.rate_sel      = st_next.control[1:0];
    st_next.cfg.rate_timer    = (st_next.control[3:0] == MD_SPI_MTMR);
    st_next.cfg.spi_slave     = mode_is_spi_slave(st_next.control[3:0]);
    st_next.cfg.ss_gating     = (st_next.control[3:0] == MD_SPI_S_SS);
    st_next.cfg.i2c_slave     = mode_is_i2c_slave(st_next.control[3:0]);
    st_next.cfg.addr10        = st_next.control[0] && st_next.cfg.i2c_slave;
    st_next.cfg.cond_irq_en   = st_next.control[3] && st_next.cfg.i2c_slave;
    st_next.cfg.i2c_master    = (st_next.control[3:0] == MD_I2C_M);
    st_next.cfg.fw_master     = (st_next.control[3:0] == MD_I2C_FW);
    st_next.cfg.load_mask     = (st_next.control[3:0] == MD_LOAD_MASK);
    st_next.cfg.clk_idle_high = st_next.control[CT_CKP];
    st_next.cfg.shift_on_rise = st_next.status[ST_CKE] ^ st_next.control[CT_CKP];
    st_next.cfg.sample_at_end = st_next.status[ST_SMP] && st_next.cfg.spi_master;
    st_next.cfg.slew_limit_en = !st_next.status[ST_SMP] &&
                                mode_is_i2c(st_next.control[3:0]);
    st_next.cfg.scl_hold      = st_next.cfg.i2c_slave && !st_next.control[CT_CKP];
    st_next.cfg.seq_enable    = st_next.seq;
    st_next.cfg.port_idle     = !(st_next.status[ST_RW] | (|st_next.seq));
    st_next.cfg.addr_div      = st_next.addr_div;
  end

  // single state register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg          <= '0;
      st_reg.wr_st    <= WR_IDLE;
      st_reg.rd_st    <= RD_IDLE;
      st_reg.awready  <= 1'b1;
      st_reg.wready   <= 1'b1;
      st_reg.arready  <= 1'b1;
      st_reg.status   <= RST_STATUS;
      st_reg.control  <= RST_CONTROL;
      st_reg.xfer_buf <= RST_BYTE;
      st_reg.addr_div <= RST_BYTE;
      st_reg.seq      <= RST_SEQ;
      st_reg.cfg.port_idle     <= 1'b1;
      st_reg.cfg.spi_master    <= 1'b1;
      st_reg.cfg.slew_limit_en <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o  = st_reg.wready;
  assign s_axi_bvalid_o  = st_reg.wr_st[0];
  assign s_axi_bresp_o   = st_reg.bresp;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rvalid_o  = st_reg.rd_st[0];
  assign s_axi_rdata_o   = st_reg.rdata;
  assign s_axi_rresp_o   = st_reg.rresp;
  assign cfg_o           = st_reg.cfg;
  assign tx_load_o       = st_reg.tx_load;
  assign tx_byte_o       = st_reg.xfer_buf;
  assign byte_irq_o      = st_reg.byte_irq;

  // checks on flags and configuration
  ovf_on_full_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    evt_i.byte_done && st_reg.status[ST_BF] && !buf_rd |=> st_reg.control[CT_OVF])
    else $error("overflow not raised on full buffer");

  ovf_keeps_buf_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    evt_i.byte_done && st_reg.status[ST_BF] && !buf_rd && !buf_wr |=> $stable(st_reg.xfer_buf))
    else $error("buffer overwritten on overflow");

  byte_to_buf_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    evt_i.byte_done && (!st_reg.status[ST_BF] || buf_rd)
    |=> st_reg.status[ST_BF] && st_reg.xfer_buf == $past(evt_i.rx_byte) && byte_irq_o)
    else $error("received byte not moved to buffer");

  cond_cleared_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !st_reg.control[CT_EN] |-> !st_reg.status[ST_S] && !st_reg.status[ST_P])
    else $error("start or stop flag set while disabled");

  master_write_collision_flag_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    buf_wr && in_i2c_m && !bus_idle |=> st_reg.control[CT_WRITE_COLLISION_FLAG] && !tx_load_o)
    else $error("busy master write not flagged");

  scl_stretch_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    cfg_o.scl_hold == (mode_is_i2c_slave(mode) && !st_reg.control[CT_CKP]))
    else $error("clock stretch does not follow polarity bit");

  shift_edge_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    cfg_o.shift_on_rise == (st_reg.status[ST_CKE] != st_reg.control[CT_CKP]))
    else $error("shift edge wrong for polarity");

  bf_read_clr_a: assert property (
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    buf_rd && !evt_i.byte_done && !buf_wr |=> !st_reg.status[ST_BF])
    else $error("buffer full not cleared by read");

endmodule
`default_nettype wire

/* File: tb/sspc_engine_model.sv */
// far-side shift engine model: byte, bus condition and transmit events
`timescale 1ns/1ps
`default_nettype none
module sspc_engine_model (
  input  wire logic          clk_sys_i,
  input  wire logic          tx_load_i,
  output sspc_pkg::sspc_evt_t evt_o
);
  import sspc_pkg::*;
  sspc_evt_t  ev_r   = '0;
  logic       busy_r = 1'b0;
  logic       done_r = 1'b0;
  logic [3:0] cnt_r  = 4'h0;

  // a loaded word shifts for twelve cycles, then one done pulse
  always @(posedge clk_sys_i) begin
    done_r <= 1'b0;
    if (tx_load_i) begin
      busy_r <= 1'b1;
      cnt_r  <= 4'hB;
    end else if (busy_r) begin
      if (cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // transmit state overrides the event pulses
  always_comb begin
    evt_o         = ev_r;
    evt_o.tx_busy = busy_r;
    evt_o.tx_done = done_r;
  end

  // one-cycle event; the byte lines then show the inverse, not the old value
  task automatic send(input sspc_evt_t e);
    sspc_evt_t z;
    z = '0;
    z.rx_byte = ~e.rx_byte;
    @(posedge clk_sys_i);
    ev_r <= e;
    @(posedge clk_sys_i);
    ev_r <= z;
  endtask

  // eighth bit in: byte handed over with its kind
  task automatic recv(input logic [7:0] b, input logic is_data);
    sspc_evt_t e;
    e = '0;
    e.byte_done = 1'b1;
    e.rx_byte = b;
    e.rx_is_data = is_data;
    send(e);
  endtask
endmodule
`default_nettype wire

/* File: tb/sync_serial_port_control_test.sv */
// self-checking bench for the serial port register bank
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_control_test;
  import sspc_pkg::*;
  logic        clk_sys_i, arst_n_i, awvalid, wvalid, arvalid, awready, wready;
  logic        bvalid, arready, rvalid, tx_load, byte_irq;
  logic [7:0]  awaddr, araddr, tx_byte, v, b;
  logic [31:0] wdata, rdata, lfsr, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  sspc_evt_t   evt, e;
  sspc_cfg_t   cfg;
  int          num_errors, n_checks;

  sspc_regs dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .evt_i(evt), .cfg_o(cfg), .tx_load_o(tx_load),
    .tx_byte_o(tx_byte), .byte_irq_o(byte_irq));
  sspc_engine_model eng_u (.clk_sys_i(clk_sys_i), .tx_load_i(tx_load), .evt_o(evt));

  // free-running system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // write: address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
  endtask

  // read: waits for the answer, only the watchdog ends a hang
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    axi_rd(a);
    check("register", rd & {24'hFFFFFF, m}, {24'h000000, x});
  endtask

  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    test_done();
  end

  // main sequence
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    arst_n_i = 1'b0;
    lfsr = 32'd68921;
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd_chk(OFS_STATUS, 8'hFF, RST_STATUS);
    rd_chk(OFS_CONTROL, 8'hFF, RST_CONTROL);
    check("idle", {cfg.spi_master, cfg.port_idle}, 2'b11);
    // random settings of sample, edge, polarity, enable and mode
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      v = lfsr[7:0];
      axi_wr(OFS_STATUS, v);
      axi_wr(OFS_CONTROL, v);
      rd_chk(OFS_STATUS, 8'hFF, {v[7:6], 6'h00});
      rd_chk(OFS_CONTROL, 8'hFF, {2'b00, v[5:0]});
      check("pins", {cfg.pins_owned, cfg.clk_idle_high}, v[5:4]);
      check("edge", cfg.shift_on_rise, v[6] ^ v[4]);
      if (v[3:0] < 4'h4) check("phase", cfg.sample_at_end, v[7]);
      if (v[3:0] inside {4'h6, 4'h7, 4'h8, 4'hE, 4'hF}) check("slew", cfg.slew_limit_en, !v[7]);
      if (v[3:0] inside {4'h6, 4'h7, 4'hE, 4'hF}) check("stretch", cfg.scl_hold, !v[4]);
    end
    // every mode code
    for (int m = 0; m < 16; m++) begin
      axi_wr(OFS_CONTROL, {4'h2, m[3:0]});
      if (m <= 8 || m >= 14) check("mode", {cfg.spi_master, cfg.spi_slave, cfg.i2c_slave,
        cfg.i2c_master}, {m < 4, m inside {4, 5}, m inside {6, 7, 14, 15}, m == 8});
      if (m < 4) check("rate", {cfg.rate_timer, cfg.rate_sel}, {m == 3, m[1:0]});
      check("gate", cfg.ss_gating, m == 4);
      if (m inside {6, 7, 14, 15}) check("addr", {cfg.addr10, cfg.cond_irq_en}, {m[0], m[3]});
      if (m inside {9, 11}) check("special", {cfg.load_mask, cfg.fw_master}, {m == 9, m == 11});
    end
    axi_wr(8'h14, 8'h5A);
    check("bresp", rs, RESP_SLVERR);
    axi_rd(8'h14);
    check("rresp", rs, RESP_SLVERR);
    check("rdata", rd, 32'h0);
    // spi slave receive, then overflow on an unread buffer
    axi_wr(OFS_STATUS, 8'h00);
    axi_wr(OFS_CONTROL, 8'h25);
    lfsr = nxt(lfsr);
    b = lfsr[7:0];
    eng_u.recv(b, 1'b1);
    @(negedge clk_sys_i);
    check("byte irq", byte_irq, 1'b1);
    @(posedge clk_sys_i);
    rd_chk(OFS_STATUS, 8'hFF, 8'h01);
    eng_u.recv(~b, 1'b1);
    rd_chk(OFS_CONTROL, 8'hFF, 8'h65);
    rd_chk(OFS_BUFFER, 8'hFF, b);
    rd_chk(OFS_STATUS, 8'h01, 8'h00);
    axi_wr(OFS_CONTROL, 8'h25);
    rd_chk(OFS_CONTROL, 8'hFF, 8'h25);
    // i2c slave, 10-bit: start, matched read address, update, data, stop
    axi_wr(OFS_CONTROL, 8'h37);
    e = '0;
    e.start_seen = 1'b1;
    eng_u.send(e);
    rd_chk(OFS_STATUS, 8'h18, 8'h08);
    e = '0;
    e.addr_match = 1'b1;
    e.addr_rw = 1'b1;
    e.ua_req = 1'b1;
    eng_u.send(e);
    rd_chk(OFS_STATUS, 8'h06, 8'h06);
    // a write without the low lane has no effect
    wstrb <= 4'hE;
    axi_wr(OFS_ADDRDIV, ~b);
    check("bresp", rs, RESP_OKAY);
    rd_chk(OFS_STATUS, 8'h02, 8'h02);
    wstrb <= 4'hF;
    axi_wr(OFS_ADDRDIV, b);
    rd_chk(OFS_STATUS, 8'h02, 8'h00);
    check("divider", cfg.addr_div, b);
    eng_u.recv(b, 1'b1);
    rd_chk(OFS_STATUS, 8'h21, 8'h21);
    eng_u.recv(~b, 1'b1);
    rd_chk(OFS_CONTROL, 8'h40, 8'h40);
    rd_chk(OFS_BUFFER, 8'hFF, b);
    e = '0;
    e.stop_seen = 1'b1;
    eng_u.send(e);
    rd_chk(OFS_STATUS, 8'h18, 8'h10);
    axi_wr(OFS_CONTROL, 8'h17);
    rd_chk(OFS_STATUS, 8'h18, 8'h00);
    // transmit, then a second buffer write while busy, in spi slave and i2c master
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h28 : 8'h25;
      axi_wr(OFS_CONTROL, v);
      axi_wr(OFS_BUFFER, b);
      // engine reports busy a cycle after the load, flag a cycle later
      repeat (2) @(posedge clk_sys_i);
      if (k) rd_chk(OFS_STATUS, 8'h05, 8'h05);
      if (k) check("busy", cfg.port_idle, 1'b0);
      axi_wr(OFS_BUFFER, ~b);
      rd_chk(OFS_CONTROL, 8'hBF, v | 8'h80);
      check("tx byte", tx_byte, b);
      repeat (16) @(posedge clk_sys_i);
      if (k) rd_chk(OFS_STATUS, 8'h05, 8'h00);
    end
    axi_wr(OFS_SEQUENCE, 8'h01);
    check("seq", {cfg.seq_enable, cfg.port_idle}, 6'b000010);
    e = '0;
    e.seq_done = 5'h01;
    eng_u.send(e);
    #1 check("seq done", {cfg.seq_enable, cfg.port_idle}, 6'b000001);
    test_done();
  end
endmodule
`default_nettype wire
